// *** logic/pirq_pkg.sv ***
// Constants and register map of the port interrupt priority controller
//------------------------------------------------------------------
//------------------------------------------------------------------
package pirq_pkg;
  localparam int NSRC = 14;
  localparam int SRC_W = 4;
  localparam int AW = 12;
  localparam int DW = 32;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_REQ = 8'hc0;
  localparam logic [7:0] IDX_EN = 8'he8;
  localparam logic [7:0] IDX_POL = 8'he9;
  localparam logic [7:0] IDX_PRI = 8'hf8;
  localparam logic [7:0] IDX_CEN = 8'ha8;
  localparam logic [7:0] IDX_CPRI = 8'hb8;
  localparam logic [7:0] IDX_STAT = 8'h10;
  localparam int IDX_LSB = 2;
  // Classic enable layout: bit 7 global, bits 5..0 classic sources
  localparam int GLOBAL_EN_BIT = 7;
  localparam int NCLASSIC = 6;
  localparam logic [7:0] RST_VAL = 8'h00;
  // Status layout
  localparam int ST_VEC_LSB = 8;
  // Machine cycle length in clocks
  localparam logic [3:0] MC_CLKS = 4'hc;
  // Vector base and step
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam logic [15:0] VEC_STEP = 16'h0008;
  // Source numbering
  localparam logic [3:0] S_EXT0 = 4'h0, S_TF0 = 4'h1, S_EXT1 = 4'h2;
  localparam logic [3:0] S_TF1 = 4'h3, S_SER = 4'h4, S_TF2 = 4'h5;
  localparam logic [3:0] S_EXT2 = 4'h6, S_EXT3 = 4'h7, S_EXT4 = 4'h8;
  localparam logic [3:0] S_EXT5 = 4'h9, S_EXT6 = 4'ha, S_EXT7 = 4'hb;
  localparam logic [3:0] S_EXT8 = 4'hc, S_EXT9 = 4'hd;
  localparam logic [3:0] S_NONE = 4'hf;
  // Polling order, first entry wins
  localparam logic [3:0] POLL [NSRC] = '{S_EXT0, S_EXT5, S_TF0,
    S_EXT6, S_EXT1, S_EXT2, S_EXT7, S_TF1, S_SER, S_TF2, S_EXT3,
    S_EXT8, S_EXT4, S_EXT9};
  typedef enum logic [1:0] {
    PIRQ_IDLE = 2'b00,
    PIRQ_REQ  = 2'b01
  } pirq_state_e;
endpackage

// *** logic/pirq_ctrl.sv ***
// Port interrupt priority controller with APB register access
`timescale 1ns/1ps
module pirq_ctrl
(
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       clk_en,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [pirq_pkg::AW-1:0]    paddr,
  input  wire logic [pirq_pkg::DW-1:0]    pwdata,
  output logic                            pready,
  output logic [pirq_pkg::DW-1:0]         prdata,
  output logic                            pslverr,
  input  wire logic [7:0]                 port_pins,
  input  wire logic                       external_zero,
  input  wire logic                       external_one,
  input  wire logic                       timer_zero_overflow,
  input  wire logic                       timer_one_overflow,
  input  wire logic                       timer_two_overflow,
  input  wire logic                       serial_port_irq,
  input  wire logic                       power_down,
  input  wire logic                       cpu_ack,
  input  wire logic                       cpu_reti,
  output logic                            irq_req,
  output logic [15:0]                     irq_vector,
  output logic                            irq_high,
  output logic                            wake_up
);
  import pirq_pkg::*;

  //------------------------------------------------------------
  // Registers and state
  //------------------------------------------------------------
  logic [7:0]  port_irq_request_flags;
  logic [7:0]  port_irq_enables;
  logic [7:0]  port_irq_polarity;
  logic [7:0]  port_irq_priority;
  logic [7:0]  classic_enables;
  logic [7:0]  classic_priority;
  logic [3:0]  mc_count;
  logic        mc_tick;
  logic [7:0]  active_prev;
  logic [7:0]  active_now;
  logic [7:0]  recognised;
  logic        in_svc_hi;
  logic        in_svc_lo;
  logic [3:0]  cur_src;
  pirq_state_e state;

  logic        apb_access;
  logic        apb_write;
  logic [7:0]  reg_idx;
  logic        idx_ok;
  logic [7:0]  wbyte;
  logic [7:0]  rd_byte;
  logic [15:0] stat_word;

  logic [NSRC-1:0] pend;
  logic [NSRC-1:0] prio;
  logic [3:0]  sel_hi;
  logic [3:0]  sel_lo;
  logic [3:0]  next_src;
  logic        next_valid;
  logic        next_high;

  //------------------------------------------------------------
  // Machine cycle timing
  //------------------------------------------------------------
  // Tick once every machine cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mc_count <= 4'h0;
    end else if (clk_en) begin
      if (mc_count == MC_CLKS - 4'h1) begin
        mc_count <= 4'h0;
      end else begin
        mc_count <= mc_count + 4'h1;
      end
    end
  end

  assign mc_tick = (mc_count == MC_CLKS - 4'h1);

  //------------------------------------------------------------
  // Port line level detection
  //------------------------------------------------------------
  // Polarity bit high selects active high
  assign active_now = ~(port_pins ^ port_irq_polarity);

  // Sample active level once per machine cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_prev <= RST_VAL;
    end else if (clk_en && mc_tick) begin
      active_prev <= active_now;
    end
  end

  // Active at two samples a machine cycle apart
  assign recognised = active_prev & active_now;

  //------------------------------------------------------------
  // APB decode
  //------------------------------------------------------------
  assign apb_access = psel && penable && pready;
  assign apb_write = apb_access && pwrite;
  assign reg_idx = paddr[IDX_LSB +: 8];
  assign wbyte = pwdata[7:0];

  // Known word-aligned register indices
  always_comb begin
    idx_ok = (paddr[IDX_LSB-1:0] == '0) && (paddr[AW-1] == 1'b0);
    case (reg_idx)
      IDX_REQ, IDX_EN, IDX_POL, IDX_PRI,
      IDX_CEN, IDX_CPRI, IDX_STAT: idx_ok = idx_ok;
      default: idx_ok = 1'b0;
    endcase
  end

  //------------------------------------------------------------
  // Request flags
  //------------------------------------------------------------
  // Hardware set wins over a software write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_irq_request_flags <= RST_VAL;
    end else if (clk_en) begin
      if (apb_write && idx_ok && reg_idx == IDX_REQ) begin
        port_irq_request_flags <= wbyte;
      end
      if (mc_tick) begin
        port_irq_request_flags <= (apb_write && idx_ok
          && reg_idx == IDX_REQ ? wbyte : port_irq_request_flags)
          | (recognised & port_irq_enables);
      end
    end
  end

  //------------------------------------------------------------
  // Configuration registers
  //------------------------------------------------------------
  // Port enables, one bit per extra interrupt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_irq_enables <= RST_VAL;
    end else if (clk_en && apb_write && idx_ok
                 && reg_idx == IDX_EN) begin
      port_irq_enables <= wbyte;
    end
  end

  // Port polarity, one bit per pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_irq_polarity <= RST_VAL;
    end else if (clk_en && apb_write && idx_ok
                 && reg_idx == IDX_POL) begin
      port_irq_polarity <= wbyte;
    end
  end

  // Port priority, one level bit per extra interrupt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_irq_priority <= RST_VAL;
    end else if (clk_en && apb_write && idx_ok
                 && reg_idx == IDX_PRI) begin
      port_irq_priority <= wbyte;
    end
  end

  // Classic source enables and global enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      classic_enables <= RST_VAL;
    end else if (clk_en && apb_write && idx_ok
                 && reg_idx == IDX_CEN) begin
      classic_enables <= wbyte;
    end
  end

  // Classic source priorities
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      classic_priority <= RST_VAL;
    end else if (clk_en && apb_write && idx_ok
                 && reg_idx == IDX_CPRI) begin
      classic_priority <= wbyte;
    end
  end

  //------------------------------------------------------------
  // Source gathering and polling
  //------------------------------------------------------------
  // Fourteen requests in source order
  assign pend = {port_irq_request_flags & port_irq_enables,
                 classic_enables[NCLASSIC-1:0]
                 & {timer_two_overflow, serial_port_irq,
                    timer_one_overflow, external_one,
                    timer_zero_overflow, external_zero}};
  assign prio = {port_irq_priority,
                 classic_priority[NCLASSIC-1:0]};

  // Walk the poll list backwards so the first entry wins
  always_comb begin
    sel_hi = S_NONE;
    sel_lo = S_NONE;
    for (int k = NSRC - 1; k >= 0; k--) begin
      if (pend[POLL[k]] && prio[POLL[k]]) begin
        sel_hi = POLL[k];
      end
      if (pend[POLL[k]] && !prio[POLL[k]]) begin
        sel_lo = POLL[k];
      end
    end
  end

  // Pick a level that may preempt the routine in progress
  always_comb begin
    next_src = S_NONE;
    next_valid = 1'b0;
    next_high = 1'b0;
    if (classic_enables[GLOBAL_EN_BIT] && !in_svc_hi) begin
      if (sel_hi != S_NONE) begin
        next_src = sel_hi;
        next_valid = 1'b1;
        next_high = 1'b1;
      end else if (sel_lo != S_NONE && !in_svc_lo) begin
        next_src = sel_lo;
        next_valid = 1'b1;
      end
    end
  end

  // Vector address of a source
  function automatic logic [15:0] vec_of(input logic [3:0] s);
    logic [15:0] slot;
    slot = {12'h000, s};
    if (s >= S_EXT2) begin
      slot = slot + 16'h0001;
    end
    vec_of = VEC_BASE + 16'(slot * VEC_STEP);
  endfunction

  //------------------------------------------------------------
  // Request to the CPU core
  //------------------------------------------------------------
  // Offer at a machine cycle boundary, after the flag settled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= PIRQ_IDLE;
      irq_req <= 1'b0;
      irq_vector <= 16'h0000;
      irq_high <= 1'b0;
      cur_src <= S_NONE;
    end else if (clk_en) begin
      case (state)
        PIRQ_IDLE: begin
          if (mc_tick && next_valid) begin
            state <= PIRQ_REQ;
            irq_req <= 1'b1;
            irq_vector <= vec_of(next_src);
            irq_high <= next_high;
            cur_src <= next_src;
          end
        end
        PIRQ_REQ: begin
          if (cpu_ack) begin
            state <= PIRQ_IDLE;
            irq_req <= 1'b0;
          end else if (mc_tick) begin
            if (next_valid) begin
              irq_vector <= vec_of(next_src);
              irq_high <= next_high;
              cur_src <= next_src;
            end else begin
              state <= PIRQ_IDLE; // Request went away
              irq_req <= 1'b0;
            end
          end
        end
        default: begin
          state <= PIRQ_IDLE;
          irq_req <= 1'b0;
        end
      endcase
    end
  end

  //------------------------------------------------------------
  // In-service levels
  //------------------------------------------------------------
  // Ack marks a level busy; return frees the highest one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_svc_hi <= 1'b0;
      in_svc_lo <= 1'b0;
    end else if (clk_en) begin
      if (cpu_ack && irq_req) begin
        if (irq_high) begin
          in_svc_hi <= 1'b1;
        end else begin
          in_svc_lo <= 1'b1;
        end
      end else if (cpu_reti) begin
        if (in_svc_hi) begin
          in_svc_hi <= 1'b0;
        end else begin
          in_svc_lo <= 1'b0;
        end
      end
    end
  end

  //------------------------------------------------------------
  // Power-down wake
  //------------------------------------------------------------
  // Any enabled port line at its active level wakes the chip
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_up <= 1'b0;
    end else if (clk_en) begin
      wake_up <= power_down
                 && |(active_now & port_irq_enables);
    end
  end

  //------------------------------------------------------------
  // APB read and response
  //------------------------------------------------------------
  assign stat_word = {irq_vector[7:0], 2'b00, in_svc_hi,
                      in_svc_lo, cur_src};

  // Read mux
  always_comb begin
    case (reg_idx)
      IDX_REQ: rd_byte = port_irq_request_flags;
      IDX_EN: rd_byte = port_irq_enables;
      IDX_POL: rd_byte = port_irq_polarity;
      IDX_PRI: rd_byte = port_irq_priority;
      IDX_CEN: rd_byte = classic_enables;
      IDX_CPRI: rd_byte = classic_priority;
      default: rd_byte = 8'h00;
    endcase
  end

  // One wait state, then ready with data or error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      if (psel && penable && !pready) begin
        pready <= 1'b1;
        pslverr <= !idx_ok;
        if (!pwrite && idx_ok && reg_idx == IDX_STAT) begin
          prdata <= {16'h0000, stat_word};
        end else if (!pwrite && idx_ok) begin
          prdata <= {24'h00_0000, rd_byte};
        end else begin
          prdata <= '0;
        end
      end else begin
        pready <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

endmodule

// *** dv/pirq_checker.sv ***
// Port assertions of the port interrupt controller
`timescale 1ns/1ps
module pirq_checker (
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic                    clk_en,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pready,
  input wire logic [pirq_pkg::DW-1:0] prdata,
  input wire logic                    pslverr,
  input wire logic                    power_down,
  input wire logic                    cpu_ack,
  input wire logic                    irq_req,
  input wire logic [15:0]             irq_vector,
  input wire logic                    wake_up
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       req_q;
  logic [3:0] since_rise;
  // Cycles since the request last rose
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_q      <= 1'b0;
      since_rise <= 4'hf;
    end else begin
      req_q <= irq_req;
      if (irq_req && !req_q) begin
        since_rise <= 4'h0;
      end else if (clk_en && since_rise != 4'hf) begin
        since_rise <= since_rise + 4'h1;
      end
    end
  end
  // --------
  // Checks
  // --------
  a_pready_pulse: assert property (
    pready |=> !pready) else $error("ready held too long");
  a_pready_access: assert property (
    clk_en && psel && penable && !pready |=> pready)
    else $error("ready late");
  a_err_data_zero: assert property (
    pready && pslverr |-> prdata == '0) else $error("error data");
  a_upper_zero: assert property (
    pready |-> prdata[31:8] == 24'h00_0000) else $error("upper bits");
  a_ack_drops_req: assert property (
    clk_en && cpu_ack && irq_req |=> !irq_req)
    else $error("request kept after ack");
  a_vec_legal: assert property (
    irq_req |-> irq_vector[2:0] == 3'b011 && irq_vector <= 16'h0073
    && irq_vector != 16'h0033) else $error("bad vector");
  a_wake_cause: assert property (
    wake_up |-> $past(power_down)) else $error("wake without sleep");
  a_req_tick_gap: assert property (
    irq_req && !req_q |-> since_rise >= 4'hb)
    else $error("request rose between ticks");
  c_taken: cover property (irq_req && cpu_ack);
  c_wake: cover property (wake_up);
  c_refused: cover property (pready && pslverr);
endmodule

bind pirq_ctrl pirq_checker u_chk (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
  .penable(penable), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .power_down(power_down), .cpu_ack(cpu_ack),
  .irq_req(irq_req), .irq_vector(irq_vector), .wake_up(wake_up));

// *** dv/pirq_core_model.sv ***
// Behavioural CPU core that takes and returns from interrupts
`timescale 1ns/1ps
module pirq_core_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        irq_req,
  input  wire logic [15:0] irq_vector,
  input  wire logic        irq_high,
  input  wire logic [7:0]  ack_dly,
  input  wire logic [7:0]  svc_dly,
  output logic             cpu_ack,
  output logic             cpu_reti,
  output logic [15:0]      taken_vec,
  output logic             taken_high,
  output logic [7:0]       n_taken,
  output logic [7:0]       depth
);
  logic [7:0] wait_cnt;
  // Ack offered vector after a delay, return after service time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {cpu_ack, cpu_reti, taken_vec, taken_high} <= '0;
      {n_taken, depth, wait_cnt} <= '0;
    end else begin
      cpu_ack  <= 1'b0;
      cpu_reti <= 1'b0;
      if (irq_req && !cpu_ack && wait_cnt >= ack_dly) begin
        cpu_ack    <= 1'b1;
        taken_vec  <= irq_vector;
        taken_high <= irq_high;
        n_taken    <= n_taken + 8'h01;
        depth      <= depth + 8'h01;
        wait_cnt   <= 8'h00;
      end else if (!irq_req && depth == 8'h00) begin
        wait_cnt <= 8'h00;
      end else if (!irq_req && wait_cnt >= svc_dly) begin
        cpu_reti <= 1'b1;
        depth    <= depth - 8'h01;
        wait_cnt <= 8'h00;
      end else if (!cpu_ack) begin
        wait_cnt <= wait_cnt + 8'h01;
      end
    end
  end
endmodule

// *** dv/tb_top.sv ***
// Self-checking bench of the port interrupt controller
`timescale 1ns/1ps
module tb_top;
  import pirq_pkg::*;
  logic          pclk = 0, presetn = 0, psel = 0, penable = 0;
  logic          pwrite = 0, pd = 0, ce = 1, ack, reti, thigh, err;
  logic          pready, pslverr, irq_req, irq_high, wake_up;
  logic [AW-1:0] paddr = '0;
  logic [DW-1:0] pwdata = '0, prdata, rd;
  logic [15:0]   irq_vector, tvec;
  logic [7:0]    pins = 8'hff, pol = 8'h00, adly = 8'h02;
  logic [7:0]    sdly = 8'h10, ntk, dep, d, n = 8'h00;
  logic [5:0]    cls = 6'h00;
  logic [11:0]   ra [4] = '{12'h300, 12'h3a4, 12'h3e0, 12'h3a0};
  int            k, off, t, n_mismatch = 0, n_tests = 0;
  always #5 pclk = ~pclk;
  pirq_ctrl DUT (
    .pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .port_pins(pins), .external_zero(cls[0]), .external_one(cls[2]),
    .timer_zero_overflow(cls[1]), .timer_one_overflow(cls[3]),
    .timer_two_overflow(cls[5]), .serial_port_irq(cls[4]),
    .power_down(pd), .cpu_ack(ack), .cpu_reti(reti), .irq_req(irq_req),
    .irq_vector(irq_vector), .irq_high(irq_high), .wake_up(wake_up));
  pirq_core_model u_core (
    .pclk(pclk), .presetn(presetn), .irq_req(irq_req),
    .irq_vector(irq_vector), .irq_high(irq_high), .ack_dly(adly),
    .svc_dly(sdly), .cpu_ack(ack), .cpu_reti(reti), .taken_vec(tvec),
    .taken_high(thigh), .n_taken(ntk), .depth(dep));
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // One APB transfer, waits for ready
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for ready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Drive a source active or idle
  task automatic drv(input int s, input logic on);
    if (s < 6) cls[s] <= on;
    else pins[s-6] <= on ~^ pol[s-6];
  endtask
  // Expected vector of a source
  function automatic logic [15:0] vec(input int s);
    return 16'(3 + 8 * (s < 6 ? s : s + 1));
  endfunction
  // Wait up to 600 clocks for the core to take one more vector
  task automatic take();
    n++;
    t = 0;
    while (ntk !== n && t < 600) begin
      @(posedge pclk);
      t++;
    end
    chk(ntk, n);
  endtask
  task automatic idle();
    t = 0;
    while (dep !== 8'h00 && t < 1000) begin
      @(posedge pclk);
      t++;
    end
    chk(dep, 8'h00);
    repeat (24) @(posedge pclk);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #200000;
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'h0000_29dd));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values and random read-back
    foreach (ra[i]) begin
      apb(1'b0, ra[i], 8'h00);
      chk(rd, 32'h0000_0000);
      d = 8'($urandom);
      apb(1'b1, ra[i], d);
      apb(1'b0, ra[i], 8'h00);
      chk(rd, {24'h00_0000, d});
    end
    apb(1'b1, 12'h3a0, 8'h00);
    pol = 8'($urandom);
    apb(1'b1, 12'h3a4, pol);
    pins <= ~pol;
    apb(1'b1, 12'h300, 8'h00);
    apb(1'b1, 12'h3e0, 8'h00);
    apb(1'b1, 12'h104, 8'hff);
    chk(err, 1'b1);
    apb(1'b0, 12'h104, 8'h00);
    chk(err, 1'b1);
    chk(rd, 32'h0000_0000);
    apb(1'b1, 12'h2a0, 8'hbf);
    // Disabled line and short pulse set no flag
    k = $urandom % 8;
    drv(6 + k, 1'b1);
    repeat (36) @(posedge pclk);
    drv(6 + k, 1'b0);
    apb(1'b1, 12'h3a0, 8'(1 << k));
    apb(1'b0, 12'h300, 8'h00);
    chk(rd, 32'h0000_0000);
    drv(6 + k, 1'b1);
    repeat (5) @(posedge pclk);
    drv(6 + k, 1'b0);
    repeat (36) @(posedge pclk);
    apb(1'b0, 12'h300, 8'h00);
    chk(rd, 32'h0000_0000);
    // Each port line alone, in turn from a random first line
    off = $urandom % 8;
    for (int i = 0; i < 8; i++) begin
      k = (i + off) % 8;
      apb(1'b1, 12'h3a0, 8'(1 << k));
      drv(6 + k, 1'b1);
      take();
      chk(tvec, vec(6 + k));
      chk(thigh, 1'b0);
      drv(6 + k, 1'b0);
      apb(1'b0, 12'h300, 8'h00);
      chk(rd, 32'(1 << k));
      apb(1'b1, 12'h300, 8'h00);
      idle();
    end
    // Neighbours in the polling order at once
    apb(1'b1, 12'h3a0, 8'hff);
    adly <= 8'h3c;
    for (int j = 0; j < NSRC - 1; j++) begin
      drv(POLL[j], 1'b1);
      drv(POLL[j+1], 1'b1);
      take();
      chk(tvec, vec(POLL[j]));
      drv(POLL[j], 1'b0);
      drv(POLL[j+1], 1'b0);
      apb(1'b1, 12'h300, 8'h00);
      idle();
    end
    // High level preempts a low service routine
    adly <= 8'h02;
    sdly <= 8'hc8;
    apb(1'b1, 12'h3e0, 8'h02);
    drv(0, 1'b1);
    take();
    chk(tvec, vec(0));
    drv(0, 1'b0);
    drv(7, 1'b1);
    take();
    chk({thigh, dep, tvec}, {1'b1, 8'h02, vec(7)});
    drv(7, 1'b0);
    apb(1'b1, 12'h300, 8'h00);
    idle();
    // Frozen clock counts no machine cycle, so no flag
    ce <= 1'b0;
    drv(8, 1'b1);
    repeat (36) @(posedge pclk);
    drv(8, 1'b0);
    ce <= 1'b1;
    apb(1'b0, 12'h300, 8'h00);
    chk(rd, 32'h0000_0000);
    // Wake from power-down by enabled line only
    pd <= 1'b1;
    apb(1'b1, 12'h3a0, 8'h01);
    drv(7, 1'b1);
    repeat (30) @(posedge pclk);
    chk(wake_up, 1'b0);
    drv(6, 1'b1);
    t = 0;
    while (wake_up !== 1'b1 && t < 40) begin
      @(posedge pclk);
      t++;
    end
    chk(wake_up, 1'b1);
    report_and_stop();
  end
endmodule
